// file: core/flash_guard_pkg.sv
// Shared constants, types and region lookup for the flash section write guard
package flash_guard_pkg;
    localparam int             ADDR_W        = 17;
    localparam int             PAGE_BITS     = 9;
    localparam int             PAGE_BYTES    = 512;
    localparam int             FUSE_W        = 8;
    localparam int             LIMIT_W       = 9;
    localparam logic [8:0]     FLASH_PAGES   = 9'h100;
    localparam logic [8:0]     PAGE_OFFSET_0 = 9'h000;
    localparam logic [7:0]     LOADER_FUSE_DEFAULT  = 8'h00;
    localparam logic [7:0]     PROGRAM_FUSE_DEFAULT = 8'h00;
    localparam logic [7:0]     FUSE_ZERO     = 8'h00;
    localparam logic [5:0]     MAX_ERASE_PAGES = 6'h20;
    localparam int             CNT_W         = 9;
    localparam int             OP_TIME_NS    = 1000;
    localparam int             CLK_PERIOD_NS = 4;
    localparam int             OP_CYCLES_INT = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] OP_CYCLES   = CNT_W'(OP_CYCLES_INT);

    typedef enum logic [1:0] {
        REGION_LOADER    = 2'h0,
        REGION_PROGRAM   = 2'h1,
        REGION_PARAMETER = 2'h2,
        REGION_EEPROM    = 2'h3
    } region_t;

    typedef enum logic [1:0] {
        OP_WRITE_BYTE   = 2'h0,
        OP_WRITE_WORD   = 2'h1,
        OP_ERASE_PAGES  = 2'h2,
        OP_EEPROM_WRITE = 2'h3
    } op_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } busy_state_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       data;
        logic [5:0]        pages;
    } req_t;

    typedef struct packed {
        logic              write_byte;
        logic              write_word;
        logic              erase;
        logic              eeprom;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       data;
        logic [5:0]        pages;
    } array_cmd_t;

    typedef struct packed {
        logic [LIMIT_W-1:0] loader_limit;
        logic [LIMIT_W-1:0] program_limit;
        logic               program_present;
    } region_map_t;

    function automatic region_t classify(input logic [ADDR_W-1:0] addr, input region_map_t m);
        logic [LIMIT_W-1:0] page;
        page = {1'b0, addr[ADDR_W-1:PAGE_BITS]};
        if (page < m.loader_limit)
            classify = REGION_LOADER;
        else if (m.program_present && page < m.program_limit)
            classify = REGION_PROGRAM;
        else
            classify = REGION_PARAMETER;
    endfunction
endpackage

// file: core/flash_section_write_guard.sv
// Flash section write guard: checks and launches core program/erase requests
//
// Contract
// - Flash is organised in 512-byte pages; a page is the smallest erase unit.
// - Erase covers whole pages only, one or several together.
// - Flash writes are accepted per single byte or single word.
// - Three regions: loader full access, program limited, parameter none.
// - A write to the region holding the running code is refused.
// - Program region writable only by code running from the loader region.
// - Parameter region writable only by code from loader or program region.
// - Core halts for allowed flash operations, keeps running for EEPROM.
// - Region sizes come from the two size fuses, counted in 512 bytes.
// - Loader from first byte to loader limit, program to program limit, rest parameter.
// - Zero loader fuse makes the whole array loader region.
// - Zero program fuse with nonzero loader: program to end, no parameter.
// - Data EEPROM may be programmed while the core keeps executing.
// - Program fuse not above loader fuse: no program region, parameter to end.
// - A fuse whose limit lies past the array end falls back to its default.
`timescale 1ns/10ps
module flash_section_write_guard (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_sys_rst,
    input  wire logic                        i_clk_en,
    input  wire logic [7:0]                  i_loader_size_fuse,
    input  wire logic [7:0]                  i_program_size_fuse,
    input  wire logic [16:0]                 i_exec_addr,
    input  wire logic                        i_req_valid,
    input  wire flash_guard_pkg::req_t       i_req,
    output logic                             o_req_ready,
    output logic                             o_granted,
    output logic                             o_refused,
    output logic                             o_done,
    output logic                             o_core_halt,
    output flash_guard_pkg::array_cmd_t      o_array_cmd
);
    import flash_guard_pkg::*;

    typedef struct packed {
        busy_state_t       st;
        logic [CNT_W-1:0]  count;
        logic              halt;
        logic              granted;
        logic              refused;
        logic              done;
        array_cmd_t        cmd;
    } guard_state_t;

    localparam guard_state_t RESET_STATE = '{
        st:      ST_IDLE,
        count:   '0,
        halt:    1'b0,
        granted: 1'b0,
        refused: 1'b0,
        done:    1'b0,
        cmd:     '0
    };

    guard_state_t cur;
    guard_state_t next_cur;
    region_map_t  map;

    region_map u_region_map (
        .i_core_clk          (i_core_clk),
        .i_sys_rst           (i_sys_rst),
        .i_loader_size_fuse  (i_loader_size_fuse),
        .i_program_size_fuse (i_program_size_fuse),
        .o_map               (map)
    );

    region_t            exec_region;
    region_t            target_region;
    region_t            end_region;
    logic [LIMIT_W-1:0] end_page;
    logic [ADDR_W-1:0]  end_addr;
    logic               span_ok;
    logic               access_ok;
    logic               allowed;
    logic               take;

    always_comb begin
        exec_region = classify(i_exec_addr, map);
        end_page    = LIMIT_W'({1'b0, i_req.addr[ADDR_W-1:PAGE_BITS]} + LIMIT_W'(i_req.pages) - LIMIT_W'(1));
        end_addr    = {end_page[7:0], PAGE_OFFSET_0};
        end_region  = classify(end_addr, map);
        if (i_req.op == OP_EEPROM_WRITE)
            target_region = REGION_EEPROM;
        else
            target_region = classify(i_req.addr, map);
        // Erase spans whole pages inside one region and inside the array
        if (i_req.op == OP_ERASE_PAGES)
            span_ok = (i_req.pages != 6'h00) && (i_req.pages <= MAX_ERASE_PAGES)
                      && (end_page < FLASH_PAGES) && (end_region == target_region);
        else
            span_ok = 1'b1;
        case (exec_region)
            REGION_LOADER:    access_ok = (target_region != REGION_LOADER);
            REGION_PROGRAM:   access_ok = (target_region == REGION_PARAMETER)
                                          || (target_region == REGION_EEPROM);
            REGION_PARAMETER: access_ok = 1'b0;
            default:          access_ok = 1'b0;
        endcase
        allowed = access_ok && span_ok;
    end

    assign o_req_ready = (cur.st == ST_IDLE);
    assign take        = i_clk_en && i_req_valid && o_req_ready;

    always_comb begin
        next_cur = cur;
        if (i_clk_en) begin
            next_cur.granted        = 1'b0;
            next_cur.refused        = 1'b0;
            next_cur.done           = 1'b0;
            next_cur.cmd.write_byte = 1'b0;
            next_cur.cmd.write_word = 1'b0;
            next_cur.cmd.erase      = 1'b0;
            next_cur.cmd.eeprom     = 1'b0;
            case (cur.st)
                ST_IDLE: begin
                    if (take && allowed) begin
                        next_cur.granted = 1'b1;
                        next_cur.st      = ST_RUN;
                        next_cur.count   = OP_CYCLES - CNT_W'(1);
                        next_cur.halt    = (target_region != REGION_EEPROM);
                        next_cur.cmd.data  = i_req.data;
                        next_cur.cmd.pages = i_req.pages;
                        next_cur.cmd.addr  = i_req.addr;
                        case (i_req.op)
                            OP_WRITE_BYTE: next_cur.cmd.write_byte = 1'b1;
                            OP_WRITE_WORD: begin
                                next_cur.cmd.write_word = 1'b1;
                                next_cur.cmd.addr[0]    = 1'b0;
                            end
                            OP_ERASE_PAGES: begin
                                next_cur.cmd.erase = 1'b1;
                                next_cur.cmd.addr  = {i_req.addr[ADDR_W-1:PAGE_BITS], PAGE_OFFSET_0};
                            end
                            default: next_cur.cmd.eeprom = 1'b1;
                        endcase
                    end else if (take) begin
                        next_cur.refused = 1'b1;
                    end
                end
                ST_RUN: begin
                    if (cur.count == '0) begin
                        next_cur.st   = ST_IDLE;
                        next_cur.halt = 1'b0;
                        next_cur.done = 1'b1;
                    end else begin
                        next_cur.count = cur.count - CNT_W'(1);
                    end
                end
                default: next_cur = RESET_STATE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst)
            cur <= RESET_STATE;
        else
            cur <= next_cur;
    end

    assign o_granted   = cur.granted;
    assign o_refused   = cur.refused;
    assign o_done      = cur.done;
    assign o_core_halt = cur.halt;
    assign o_array_cmd = cur.cmd;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    a_same_region_refused: assert property (take && i_req.op != OP_EEPROM_WRITE
        && classify(i_req.addr, map) == exec_region |=> o_refused && !o_granted)
        else $error("write to executing region was not refused");
    a_program_from_loader: assert property (take && target_region == REGION_PROGRAM
        && exec_region != REGION_LOADER |=> o_refused)
        else $error("program region write from non-loader code not refused");
    a_parameter_write_ok: assert property (take && i_req.op == OP_WRITE_BYTE
        && target_region == REGION_PARAMETER && exec_region != REGION_PARAMETER |=> o_granted)
        else $error("parameter byte write from loader or program code refused");
    a_parameter_exec_none: assert property (take && exec_region == REGION_PARAMETER |=> o_refused)
        else $error("code in parameter region was allowed to program");
    // Halt drops in the done cycle itself, so that cycle is exempt
    a_flash_halts_core: assert property (o_granted && !o_array_cmd.eeprom |->
        (o_core_halt || o_done) throughout (##[1:300] o_done))
        else $error("core not halted through flash operation");
    a_eeprom_core_runs: assert property (o_granted && o_array_cmd.eeprom |-> !o_core_halt [*8])
        else $error("core halted for eeprom operation");
    a_refuse_is_quiet: assert property (o_refused |-> !o_core_halt && !o_array_cmd.write_byte
        && !o_array_cmd.write_word && !o_array_cmd.erase && !o_array_cmd.eeprom)
        else $error("refused request reached the array or halted the core");
    a_erase_whole_pages: assert property (o_array_cmd.erase |-> o_array_cmd.addr[PAGE_BITS-1:0] == '0
        && o_array_cmd.pages != 6'h00 && o_array_cmd.pages <= MAX_ERASE_PAGES)
        else $error("erase not aligned to whole pages");
    a_word_write_even: assert property (o_array_cmd.write_word |-> o_array_cmd.addr[0] == 1'b0)
        else $error("word write not on even address");
    a_op_length: assert property ($rose(o_granted) && i_clk_en |=> !o_done [*8])
        else $error("operation ended too early");

    c_loader_to_program: cover property (o_granted && o_core_halt && exec_region == REGION_LOADER);
    c_eeprom_running: cover property (o_granted && o_array_cmd.eeprom);
    c_multi_erase: cover property (o_array_cmd.erase && o_array_cmd.pages > 6'h01);
    c_refused: cover property (o_refused);
endmodule // flash_section_write_guard

// file: core/region_map.sv
// Region limits derived from the two size fuses, caught during reset
`timescale 1ns/10ps
module region_map (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_sys_rst,
    input  wire logic [7:0]                  i_loader_size_fuse,
    input  wire logic [7:0]                  i_program_size_fuse,
    output flash_guard_pkg::region_map_t     o_map
);
    import flash_guard_pkg::*;

    typedef struct packed {
        logic [7:0]  loader_fuse;
        logic [7:0]  program_fuse;
        region_map_t map;
    } map_state_t;

    map_state_t cur;
    map_state_t next_cur;

    function automatic logic fuse_fits(input logic [7:0] f);
        fuse_fits = ({1'b0, f} <= FLASH_PAGES);
    endfunction

    always_comb begin
        next_cur = cur;
        if (i_sys_rst) begin
            // Out of range setting falls back to default
            next_cur.loader_fuse  = fuse_fits(i_loader_size_fuse) ? i_loader_size_fuse : LOADER_FUSE_DEFAULT;
            next_cur.program_fuse = fuse_fits(i_program_size_fuse) ? i_program_size_fuse : PROGRAM_FUSE_DEFAULT;
            if (next_cur.loader_fuse == FUSE_ZERO) begin
                next_cur.map.loader_limit    = FLASH_PAGES;
                next_cur.map.program_limit   = FLASH_PAGES;
                next_cur.map.program_present = 1'b0;
            end else begin
                next_cur.map.loader_limit = {1'b0, next_cur.loader_fuse};
                if (next_cur.program_fuse == FUSE_ZERO) begin
                    next_cur.map.program_limit   = FLASH_PAGES;
                    next_cur.map.program_present = 1'b1;
                end else if (next_cur.program_fuse <= next_cur.loader_fuse) begin
                    next_cur.map.program_limit   = {1'b0, next_cur.loader_fuse};
                    next_cur.map.program_present = 1'b0;
                end else begin
                    next_cur.map.program_limit   = {1'b0, next_cur.program_fuse};
                    next_cur.map.program_present = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        cur <= next_cur;
    end

    assign o_map = cur.map;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    a_loader_zero_whole: assert property (cur.loader_fuse == FUSE_ZERO |->
        cur.map.loader_limit == FLASH_PAGES && !cur.map.program_present)
        else $error("zero loader fuse must make whole array loader");
    a_program_zero_end: assert property (cur.loader_fuse != FUSE_ZERO && cur.program_fuse == FUSE_ZERO
        |-> cur.map.program_present && cur.map.program_limit == FLASH_PAGES)
        else $error("zero program fuse must extend program to end");
    a_program_omitted: assert property (cur.loader_fuse != FUSE_ZERO && cur.program_fuse != FUSE_ZERO
        && cur.program_fuse <= cur.loader_fuse |-> !cur.map.program_present)
        else $error("program region must be omitted");
    a_limits_follow_fuse: assert property (cur.loader_fuse != FUSE_ZERO
        && cur.program_fuse > cur.loader_fuse |-> cur.map.loader_limit == {1'b0, cur.loader_fuse}
        && cur.map.program_limit == {1'b0, cur.program_fuse})
        else $error("limits must equal fuse counts in pages");
endmodule // region_map

// file: tb/core_model.sv
// Processor core model that issues flash program and erase requests
`timescale 1ns/10ps
module core_model (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_req_ready,
    output logic                        o_req_valid,
    output flash_guard_pkg::req_t       o_req,
    output logic [16:0]                 o_exec_addr
);
    import flash_guard_pkg::*;

    initial begin
        o_req_valid = 1'b0;
        o_req       = '0;
        o_exec_addr = 17'h00000;
    end

    // Holds the request until ready is seen at a falling edge
    task automatic issue(input op_t op, input logic [16:0] a, input logic [15:0] d,
                         input logic [5:0] n, input logic [16:0] x);
        @(posedge i_core_clk);
        o_req_valid <= 1'b1;
        o_req       <= '{op: op, addr: a, data: d, pages: n};
        o_exec_addr <= x;
        @(negedge i_core_clk);
        while (i_req_ready !== 1'b1) @(negedge i_core_clk);
        @(posedge i_core_clk);
        o_req_valid <= 1'b0;
        // Released fields show the inverse so stale values are not reused
        o_req       <= req_t'(~o_req);
    endtask
endmodule // core_model

// file: tb/flash_section_write_guard_bench.sv
// Self-checking bench for the flash section write guard
`timescale 1ns/10ps
module flash_section_write_guard_bench;
    import flash_guard_pkg::*;

    logic        i_core_clk = 1'b0;
    logic        i_sys_rst  = 1'b1;
    logic [7:0]  lf         = 8'h04;
    logic [7:0]  pf         = 8'h08;
    logic        clk_en     = 1'b1;
    logic        req_valid;
    req_t        req;
    logic [16:0] exec_addr;
    logic        o_req_ready;
    logic        o_granted;
    logic        o_refused;
    logic        o_done;
    logic        o_core_halt;
    array_cmd_t  o_array_cmd;
    int          n_fail   = 0;
    int          n_checks = 0;

    always #2 i_core_clk = ~i_core_clk;

    core_model core (.i_core_clk(i_core_clk), .i_req_ready(o_req_ready), .o_req_valid(req_valid),
                     .o_req(req), .o_exec_addr(exec_addr));

    flash_section_write_guard uut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
        .i_loader_size_fuse(lf), .i_program_size_fuse(pf), .i_exec_addr(exec_addr),
        .i_req_valid(req_valid), .i_req(req), .o_req_ready(o_req_ready), .o_granted(o_granted),
        .o_refused(o_refused), .o_done(o_done), .o_core_halt(o_core_halt), .o_array_cmd(o_array_cmd));

    function automatic region_t exp_region(input logic [16:0] a);
        if (lf == 8'h00 || a[16:9] < lf) return REGION_LOADER;
        if (pf == 8'h00 || (pf > lf && a[16:9] < pf)) return REGION_PROGRAM;
        return REGION_PARAMETER;
    endfunction

    function automatic logic exp_ok(input op_t op, input logic [16:0] a, input logic [5:0] n,
                                    input logic [16:0] x);
        region_t     er;
        region_t     tr;
        logic [8:0]  last;
        er   = exp_region(x);
        tr   = exp_region(a);
        last = {1'b0, a[16:9]} + {3'b000, n} - 9'h001;
        if (er == REGION_PARAMETER) return 1'b0;
        if (op == OP_EEPROM_WRITE) return 1'b1;
        if (tr == REGION_LOADER || tr == er) return 1'b0;
        if (tr == REGION_PROGRAM && er != REGION_LOADER) return 1'b0;
        if (op == OP_ERASE_PAGES && (n == 6'h00 || n > 6'h20 || last > 9'h0FF ||
            exp_region({last[7:0], 9'h000}) != tr)) return 1'b0;
        return 1'b1;
    endfunction

    task automatic chk(input bit c, input string m);
        n_checks++;
        if (!c) begin
            n_fail++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [7:0] l, input logic [7:0] p);
        @(posedge i_core_clk);
        i_sys_rst <= 1'b1;
        lf        <= l;
        pf        <= p;
        repeat (2) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
    endtask

    task automatic run(input op_t op, input logic [16:0] a, input logic [15:0] d,
                       input logic [5:0] n, input logic [16:0] x);
        logic        ok;
        logic        fl;
        logic [16:0] ea;
        int          c;
        ok = exp_ok(op, a, n, x);
        fl = (op != OP_EEPROM_WRITE);
        ea = (op == OP_WRITE_WORD) ? {a[16:1], 1'b0} : (op == OP_ERASE_PAGES) ? {a[16:9], 9'h000} : a;
        core.issue(op, a, d, n, x);
        @(negedge i_core_clk);
        chk(o_granted === ok && o_refused === !ok, "grant or refuse wrong");
        chk(o_core_halt === (ok && fl), "halt wrong at launch");
        chk(o_array_cmd.write_byte === (ok && op == OP_WRITE_BYTE) && o_array_cmd.eeprom === (ok && !fl) &&
            o_array_cmd.write_word === (ok && op == OP_WRITE_WORD) &&
            o_array_cmd.erase === (ok && op == OP_ERASE_PAGES), "strobe wrong");
        if (ok) begin
            chk(o_array_cmd.addr === ea && o_array_cmd.data === d, "command fields");
            if (op == OP_ERASE_PAGES) chk(o_array_cmd.pages === n, "page count");
            c = 1;
            while (o_done !== 1'b1 && c < 1000) begin
                @(negedge i_core_clk);
                c++;
                chk(o_req_ready === o_done && o_core_halt === (fl && !o_done), "busy phase");
            end
            // Grant cycle plus the busy span; done comes in the cycle after
            chk(c == OP_CYCLES_INT + 1, "operation length");
        end else begin
            chk(o_req_ready === 1'b1, "ready after refuse");
        end
    endtask

    initial begin
        #(4 * 60000);
        n_fail++;
        final_report();
    end

    initial begin
        logic [7:0] cfg [4][2];
        cfg = '{'{8'h04, 8'h08}, '{8'h00, 8'h10}, '{8'h04, 8'h00}, '{8'h08, 8'h04}};
        void'($urandom(88));
        do_reset(8'h04, 8'h08);
        run(OP_WRITE_WORD, 17'h00A03, 16'hA55A, 6'h01, 17'h00010);
        run(OP_WRITE_BYTE, 17'h01001, 16'h003C, 6'h01, 17'h00800);
        run(OP_ERASE_PAGES, 17'h01000, 16'h0000, 6'h20, 17'h00800);
        run(OP_ERASE_PAGES, 17'h00E00, 16'h0000, 6'h02, 17'h00010);
        run(OP_ERASE_PAGES, 17'h02000, 16'h0000, 6'h00, 17'h00010);
        run(OP_ERASE_PAGES, 17'h02000, 16'h0000, 6'h21, 17'h00010);
        run(OP_ERASE_PAGES, 17'h1FE00, 16'h0000, 6'h02, 17'h00010);
        run(OP_WRITE_BYTE, 17'h00A00, 16'h0011, 6'h01, 17'h00900);
        run(OP_WRITE_BYTE, 17'h00100, 16'h0022, 6'h01, 17'h00010);
        run(OP_EEPROM_WRITE, 17'h00040, 16'h0033, 6'h01, 17'h02000);
        run(OP_EEPROM_WRITE, 17'h00041, 16'h0044, 6'h01, 17'h00800);
        // Frozen clock enable: the request must not be taken
        @(posedge i_core_clk);
        clk_en <= 1'b0;
        core.issue(OP_EEPROM_WRITE, 17'h00042, 16'h0055, 6'h01, 17'h00010);
        @(negedge i_core_clk);
        chk(o_granted === 1'b0 && o_refused === 1'b0 && o_req_ready === 1'b1, "taken while frozen");
        @(posedge i_core_clk);
        clk_en <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            do_reset(cfg[k][0], cfg[k][1]);
            for (int j = 0; j < 14; j++) begin
                run(op_t'($urandom % 4), 17'($urandom), 16'($urandom), 6'($urandom % 34),
                    17'($urandom));
            end
        end
        final_report();
    end
endmodule // flash_section_write_guard_bench
